//--- hw/sar_adc_sequencer.v
// control logic for the 10-bit successive-approximation converter
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "sar_adc_sequencer_regs.vh"
module sar_adc_sequencer (
   input  wire       clk,
   input  wire       srst,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   input  wire       timer0_ovf,
   input  wire       timer1_ovf,
   input  wire       timer2_low_ovf,
   input  wire       timer2_high_ovf,
   input  wire       timer2_split8,
   input  wire       timer3_low_ovf,
   input  wire       timer3_high_ovf,
   input  wire       timer3_split8,
   input  wire       external_convert_start,
   input  wire [9:0] sar_code,
   output reg  [4:0] pos_mux,
   output reg        pos_is_temp,
   output reg        pos_is_supply,
   output reg        pos_none,
   output reg  [4:0] neg_mux,
   output wire       differential,
   output reg        adc_powered,
   output reg        track,
   output reg        sar_clk_en,
   output reg        sample_hold
);
   localparam S_IDLE  = 3'b001;
   localparam S_TRACK = 3'b010;
   localparam S_CONV  = 3'b100;

   reg  [4:0] positive_select_field;
   reg  [4:0] negative_input_select;
   reg  [4:0] sar_clock_divider;
   reg        left_justify_bit;
   reg        adc_enable_bit;
   reg        low_power_track_bit;
   reg        conversion_done_flag;
   reg  [2:0] conversion_start_select;
   reg  [7:0] result_high_byte;
   reg  [7:0] result_low_byte;
   reg  [2:0] state;
   reg  [4:0] div_cnt;
   reg  [3:0] step_cnt;
   reg        pin_s1;
   reg        pin_s2;
   reg        pin_prev;
   reg        start_evt;
   reg        sw_start;
   reg [15:0] formatted;
   wire       sar_tick;
   wire       pin_rise;
   wire       t2_ovf;
   wire       t3_ovf;
   wire       busy;
   wire       finish;

   // pin is asynchronous, two stages before use
   always @(posedge clk) begin
      pin_s1   <= external_convert_start;
      pin_s2   <= pin_s1;
      // idle low after reset, so no false edge
      if (srst) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_s2;
      end
   end
   assign pin_rise = pin_s2 & ~pin_prev;

   assign differential = (negative_input_select != `NEG_GND_CODE);

   assign t2_ovf = timer2_split8 ? timer2_low_ovf : timer2_high_ovf;
   assign t3_ovf = timer3_split8 ? timer3_low_ovf : timer3_high_ovf;

   always @* begin
      sw_start = wr && (addr == `ADDR_CONTROL) && wdata[`CTL_BUSY];
      case (conversion_start_select)
         `SRC_SOFTWARE: start_evt = sw_start;
         `SRC_TIMER0:   start_evt = timer0_ovf;
         `SRC_TIMER2:   start_evt = t2_ovf;
         `SRC_TIMER1:   start_evt = timer1_ovf;
         `SRC_PIN:      start_evt = pin_rise;
         `SRC_TIMER3:   start_evt = t3_ovf;
         // reserved codes never start
         default:       start_evt = 1'b0;
      endcase
   end

   assign sar_tick = (div_cnt == sar_clock_divider);
   always @(posedge clk) begin
      if (srst || state == S_IDLE || sar_tick) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   assign busy   = (state != S_IDLE);
   // an aborted conversion must not load or flag
   assign finish = adc_enable_bit && (state == S_CONV) && sar_tick &&
                   (step_cnt == `CONV_SAR_CLKS - 4'h1);

   always @(posedge clk) begin
      if (srst) begin
         state    <= S_IDLE;
         step_cnt <= 4'h0;
      end else if (!adc_enable_bit) begin
         state    <= S_IDLE;
         step_cnt <= 4'h0;
      end else begin
         case (state)
            S_IDLE: begin
               step_cnt <= 4'h0;
               if (start_evt) begin
                  if (low_power_track_bit &&
                      conversion_start_select != `SRC_PIN) begin
                     state <= S_TRACK;
                  end else begin
                     state <= S_CONV;
                  end
               end
            end
            S_TRACK: begin
               if (sar_tick) begin
                  if (step_cnt == {2'b00, `TRACK_SAR_CLKS} - 4'h1) begin
                     state    <= S_CONV;
                     step_cnt <= 4'h0;
                  end else begin
                     step_cnt <= step_cnt + 4'h1;
                  end
               end
            end
            S_CONV: begin
               if (sar_tick) begin
                  if (finish) begin
                     state    <= S_IDLE;
                     step_cnt <= 4'h0;
                  end else begin
                     step_cnt <= step_cnt + 4'h1;
                  end
               end
            end
            default: begin
               state    <= S_IDLE;
               step_cnt <= 4'h0;
            end
         endcase
      end
   end

   always @* begin
      if (left_justify_bit) begin
         formatted = {sar_code, 6'h00};
      end else if (differential) begin
         formatted = {{6{sar_code[9]}}, sar_code};
      end else begin
         formatted = {6'h00, sar_code};
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         result_high_byte <= 8'h00;
         result_low_byte  <= 8'h00;
      end else if (finish) begin
         result_high_byte <= formatted[15:8];
         result_low_byte  <= formatted[7:0];
      end
   end

   // register writes
   always @(posedge clk) begin
      if (srst) begin
         positive_select_field   <= `RST_POS_SEL;
         negative_input_select   <= `RST_NEG_SEL;
         sar_clock_divider       <= `RST_DIVIDER;
         left_justify_bit        <= 1'b0;
         adc_enable_bit          <= 1'b0;
         low_power_track_bit     <= 1'b0;
         conversion_start_select <= `SRC_SOFTWARE;
      end else if (wr) begin
         case (addr)
            `ADDR_POS_SEL: positive_select_field <= wdata[4:0];
            `ADDR_NEG_SEL: negative_input_select <= wdata[4:0];
            `ADDR_CONFIG: begin
               sar_clock_divider <= wdata[7:3];
               left_justify_bit  <= wdata[`CFG_LJ];
            end
            `ADDR_CONTROL: begin
               adc_enable_bit          <= wdata[`CTL_EN];
               low_power_track_bit     <= wdata[`CTL_TRACK];
               conversion_start_select <= wdata[2:0];
            end
            default: ;
         endcase
      end
   end

   // set wins over a software clear in the same cycle
   always @(posedge clk) begin
      if (srst) begin
         conversion_done_flag <= 1'b0;
      end else if (finish) begin
         conversion_done_flag <= 1'b1;
      end else if (wr && addr == `ADDR_CONTROL) begin
         conversion_done_flag <= wdata[`CTL_DONE];
      end
   end

   // read data one cycle after the strobe
   always @(posedge clk) begin
      if (srst || !rd) begin
         rdata <= 8'h00;
      end else begin
         case (addr)
            `ADDR_POS_SEL: rdata <= {3'h0, positive_select_field};
            `ADDR_NEG_SEL: rdata <= {3'h0, negative_input_select};
            `ADDR_CONFIG:  rdata <= {sar_clock_divider, left_justify_bit,
                                     2'h0};
            `ADDR_RES_HIGH: rdata <= result_high_byte;
            `ADDR_RES_LOW:  rdata <= result_low_byte;
            `ADDR_CONTROL: rdata <= {adc_enable_bit, low_power_track_bit,
                                     conversion_done_flag, busy, 1'b0,
                                     conversion_start_select};
            default:       rdata <= 8'h00;
         endcase
      end
   end

   // analog-side controls, registered
   always @(posedge clk) begin
      if (srst) begin
         pos_mux       <= `RST_POS_SEL;
         pos_is_temp   <= 1'b0;
         pos_is_supply <= 1'b0;
         pos_none      <= 1'b1;
         neg_mux       <= `RST_NEG_SEL;
         adc_powered   <= 1'b0;
         track         <= 1'b0;
         sar_clk_en    <= 1'b0;
         sample_hold   <= 1'b0;
      end else begin
         pos_mux       <= positive_select_field;
         pos_is_temp   <= positive_select_field == `POS_TEMP_CODE;
         pos_is_supply <= positive_select_field == `POS_VDD_CODE;
         pos_none      <= positive_select_field > `POS_VDD_CODE;
         neg_mux       <= negative_input_select;
         adc_powered   <= adc_enable_bit;
         if (!adc_enable_bit) begin
            track <= 1'b0;
         end else if (!low_power_track_bit) begin
            track <= (state != S_CONV);
         end else if (conversion_start_select == `SRC_PIN) begin
            track <= (state == S_IDLE) && !pin_s2;
         end else begin
            track <= (state == S_TRACK);
         end
         // gated by enable so shutdown drops them at once
         sar_clk_en  <= sar_tick && busy && adc_enable_bit;
         sample_hold <= (state == S_CONV) && adc_enable_bit;
      end
   end
endmodule

//--- inc/sar_adc_sequencer_regs.vh
// register map, field positions and constants for the sar converter control
// Contract
// - converter works only while enable bit is one; otherwise idle shutdown
// - ground negative input means single-ended; anything else differential
// - single-ended codes unsigned; full scale 0x03FF right, 0xFFC0 left
// - single-ended unused result bits read zero in both justifications
// - differential codes two's complement; 0x01FF and 0xFE00 right-justified
// - right-justified differential upper bits copy the sign bit
// - left-justified differential low bits zero; 0x7FC0 and 0x8000
// - left-justify bit places code low ten or upper ten bits
// - sar clock is system clock divided by divider field plus one
// - start source chosen by start-select field among six sources
// - busy bit reads one during conversion, zero after it ends
// - busy falling sets done flag and result valid while flag set
// - timer 2/3 source uses low overflow in 8-bit, high in 16-bit
// - normal tracking: input tracked always except during conversion
// - low-power tracking: each non-pin start tracks 3 sar clocks first
// - low-power with pin source tracks while pin low, converts on rise
// - positive select: pins 0-15, temp 16, supply 17, none above; reset 0x1F
// - start codes: 000 sw,001 t0,010 t2,011 t1,100 pin,101 t3,11x reserved
// - sar clock divider is 5-bit field in configuration register
// - conversion takes at least 10 sar clocks after tracking
`ifndef SAR_ADC_SEQUENCER_REGS_VH
`define SAR_ADC_SEQUENCER_REGS_VH
`define ADDR_NEG_SEL    8'hBA
`define ADDR_POS_SEL    8'hBB
`define ADDR_CONFIG     8'hBC
`define ADDR_RES_LOW    8'hBD
`define ADDR_RES_HIGH   8'hBE
`define ADDR_CONTROL    8'hE8
`define RST_POS_SEL     5'h1F
`define RST_NEG_SEL     5'h1F
`define RST_DIVIDER     5'h1F
`define NEG_GND_CODE    5'h11
`define POS_TEMP_CODE   5'h10
`define POS_VDD_CODE    5'h11
`define CTL_EN          7
`define CTL_TRACK       6
`define CTL_DONE        5
`define CTL_BUSY        4
`define CFG_LJ          2
`define SRC_SOFTWARE    3'h0
`define SRC_TIMER0      3'h1
`define SRC_TIMER2      3'h2
`define SRC_TIMER1      3'h3
`define SRC_PIN         3'h4
`define SRC_TIMER3      3'h5
`define TRACK_SAR_CLKS  2'h3
`define CONV_SAR_CLKS   4'hA
`endif

//--- dv/sar_adc_sequencer_checker.sv
// concurrent checks on the sar converter control ports
`timescale 1ns/1ps
`include "sar_adc_sequencer_regs.vh"
module sar_adc_sequencer_checker (
   input wire       clk,
   input wire       srst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   input wire [4:0] pos_mux,
   input wire       pos_is_temp,
   input wire       pos_none,
   input wire       differential,
   input wire       adc_powered,
   input wire       track,
   input wire       sar_clk_en,
   input wire       sample_hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // eight cycles, two under the ten-cycle shortest hold at divider zero
   sequence hold_run;
      sample_hold [*8];
   endsequence
   mode_decode_a: assert property (
      wr && addr == `ADDR_NEG_SEL |=> differential ==
      (($past(wdata) & 8'h1F) != {3'h0, `NEG_GND_CODE}))
      else $error("mode decode wrong");
   temp_decode_a: assert property (
      pos_is_temp == (pos_mux == `POS_TEMP_CODE))
      else $error("temp decode wrong");
   none_decode_a: assert property (
      pos_none == (pos_mux > `POS_VDD_CODE)) else $error("none decode wrong");
   enable_follow_a: assert property (
      wr && addr == `ADDR_CONTROL |-> ##2
      adc_powered == ($past(wdata, 2) >= 8'h80))
      else $error("enable not taken");
   off_idle_a: assert property (
      !adc_powered |-> !sample_hold) else $error("converting while off");
   tick_power_a: assert property (
      sar_clk_en |-> adc_powered) else $error("tick while off");
   hold_track_a: assert property (
      sample_hold |-> !track) else $error("tracking during conversion");
   hold_min_a: assert property (
      $rose(sample_hold) |-> hold_run) else $error("conversion too short");
   pos_unused_a: assert property (
      rd && addr == `ADDR_POS_SEL |=> rdata[7:5] == 3'h0)
      else $error("unused select bits set");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker
   sar_adc_sequencer_checker_i (.clk, .srst, .addr, .wdata, .wr, .rd,
   .rdata, .pos_mux, .pos_is_temp, .pos_none, .differential, .adc_powered,
   .track, .sar_clk_en, .sample_hold);

//--- dv/analog_side_model.sv
// far side: timer overflow pulses and the analog code source
`timescale 1ns/1ps
module analog_side_model (
   input  wire       fire,
   input  wire [2:0] sel,
   input  wire       hi,
   input  wire [9:0] level,
   input  wire       sample_hold,
   output wire       timer0_ovf,
   output wire       timer1_ovf,
   output wire       timer2_low_ovf,
   output wire       timer2_high_ovf,
   output wire       timer3_low_ovf,
   output wire       timer3_high_ovf,
   output wire [9:0] sar_code
);
   // code moves outside the hold, so a late sample shows up
   assign sar_code        = sample_hold ? level : ~level;
   assign timer0_ovf      = fire && sel == 3'h1;
   assign timer1_ovf      = fire && sel == 3'h3;
   assign timer2_low_ovf  = fire && sel == 3'h2 && !hi;
   assign timer2_high_ovf = fire && sel == 3'h2 && hi;
   assign timer3_low_ovf  = fire && sel == 3'h5 && !hi;
   assign timer3_high_ovf = fire && sel == 3'h5 && hi;
endmodule

//--- dv/tb_sar_adc_sequencer.sv
// bench: register tasks, conversion table and result checks
`timescale 1ns/1ps
`include "sar_adc_sequencer_regs.vh"
module tb_sar_adc_sequencer;
   localparam [4:0] DIV = 5'h02;
   reg        clk = 0, srst = 1, wr = 0, rd = 0;
   reg        fire = 0, hi = 0, split8 = 0, pin = 0;
   reg  [7:0] addr = 0, wdata = 0, got;
   reg  [2:0] sel = 0;
   reg  [9:0] level = 0;
   wire [7:0] rdata;
   wire [9:0] sar_code;
   wire [4:0] pos_mux, neg_mux;
   wire       timer0_ovf, timer1_ovf, timer2_low_ovf, timer2_high_ovf;
   wire       timer3_low_ovf, timer3_high_ovf, pos_is_temp, pos_is_supply;
   wire       pos_none, differential, adc_powered, track, sar_clk_en;
   wire       sample_hold;
   integer    error_cnt = 0, compares = 0, cyc = 0, ticks = 0, gap = 0, i;
   sar_adc_sequencer sar_adc_sequencer_i (.*, .timer2_split8(split8),
      .timer3_split8(split8), .external_convert_start(pin));
   analog_side_model analog_side_model_i (.*);
   initial forever #12.5 clk = ~clk;
   task check(input [8*10:1] what, input [15:0] seen, input [15:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      gap <= gap + 1;
      if (sar_clk_en === 1'b1) begin
         ticks <= ticks + 1;
         gap <= 1;
         if (ticks > 0) check("tick gap", gap, DIV + 1);
      end
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         print_verdict;
      end
   end
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1;
         @(posedge clk);
         wr <= 0;
         // one idle edge so the next strobe is not set in the same step
         @(posedge clk);
      end
   endtask
   // read data lives only in the cycle after the strobe
   task rd_reg(input [7:0] a);
      begin
         addr <= a;
         rd <= 1;
         @(posedge clk);
         rd <= 0;
         @(negedge clk);
         got = rdata;
         @(posedge clk);
      end
   endtask
   task pulse(input [2:0] s, input h);
      begin
         fire <= 1;
         sel <= s;
         hi <= h;
         @(posedge clk);
         fire <= 0;
      end
   endtask
   task conv(input [2:0] s, input tm, input lj, input [4:0] neg,
             input [9:0] code, input [15:0] exp);
      begin
         level <= code;
         wr_reg(`ADDR_NEG_SEL, {3'h0, neg});
         wr_reg(`ADDR_CONFIG, {DIV, lj, 2'h0});
         wr_reg(`ADDR_CONTROL, {1'b1, tm, 3'h0, s});
         ticks = 0;
         if (s == `SRC_SOFTWARE)
            wr_reg(`ADDR_CONTROL, {1'b1, tm, 3'h2, s});
         else if (s == `SRC_PIN) begin
            repeat (4) @(posedge clk);
            check("pin track", track, 1'b1);
            pin <= 1;
            repeat (4) @(posedge clk);
         end else
            pulse(s, !split8);
         rd_reg(`ADDR_CONTROL);
         check("busy", got[4], 1'b1);
         got = 0;
         for (i = 0; i < 60 && got[5] !== 1'b1; i = i + 1)
            rd_reg(`ADDR_CONTROL);
         rd_reg(`ADDR_CONTROL);
         check("ctl done", got, {1'b1, tm, 3'h4, s});
         check("ticks", ticks, (tm && s != `SRC_PIN) ? 13 : 10);
         check("neg mux", neg_mux, neg);
         check("mode", differential, neg != `NEG_GND_CODE);
         rd_reg(`ADDR_RES_HIGH);
         check("res high", got, exp[15:8]);
         rd_reg(`ADDR_RES_LOW);
         check("res low", got, exp[7:0]);
         pin <= 0;
         wr_reg(`ADDR_CONTROL, 8'h80);
         rd_reg(`ADDR_CONTROL);
         check("cleared", got, 8'h80);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      rd_reg(`ADDR_POS_SEL);
      check("pos reset", got, 8'h1F);
      rd_reg(`ADDR_CONFIG);
      check("cfg reset", got, 8'hF8);
      rd_reg(8'h00);
      check("unmapped", got, 8'h00);
      check("none dec", pos_none, 1'b1);
      wr_reg(`ADDR_POS_SEL, 8'hF0);
      rd_reg(`ADDR_POS_SEL);
      check("pos upper", got, 8'h10);
      check("temp dec", pos_is_temp, 1'b1);
      wr_reg(`ADDR_POS_SEL, 8'h11);
      rd_reg(`ADDR_POS_SEL);
      check("vdd dec", pos_is_supply, 1'b1);
      wr_reg(`ADDR_CONTROL, 8'h10);
      rd_reg(`ADDR_CONTROL);
      check("off start", got, 8'h00);
      wr_reg(`ADDR_CONTROL, 8'h86);
      wr_reg(`ADDR_CONTROL, 8'h96);
      rd_reg(`ADDR_CONTROL);
      check("reserved", got, 8'h86);
      conv(`SRC_SOFTWARE, 0, 0, `NEG_GND_CODE, 10'h3FF, 16'h03FF);
      conv(`SRC_TIMER0, 0, 1, `NEG_GND_CODE, 10'h3FF, 16'hFFC0);
      conv(`SRC_TIMER2, 1, 1, `NEG_GND_CODE, 10'h200, 16'h8000);
      conv(`SRC_TIMER1, 0, 0, 5'h00, 10'h1FF, 16'h01FF);
      conv(`SRC_PIN, 1, 0, 5'h00, 10'h200, 16'hFE00);
      split8 <= 1;
      wr_reg(`ADDR_CONTROL, 8'h82);
      pulse(`SRC_TIMER2, 1);
      rd_reg(`ADDR_CONTROL);
      check("wrong byte", got, 8'h82);
      conv(`SRC_TIMER3, 0, 1, 5'h03, 10'h1FF, 16'h7FC0);
      conv(`SRC_TIMER2, 0, 1, 5'h10, 10'h200, 16'h8000);
      print_verdict;
   end
endmodule
